// [hdl/rps_top.sv]
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module rps_top #(
   parameter int FRAME_8K_CYC = rps_pkg::F8K_CYC,
   parameter int MFRAME_2K_CYC = rps_pkg::F2K_CYC,
   parameter int AMI_IDLE_CYC = rps_pkg::AMI_LOS_CYC
) (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire rps_pkg::rps_axi_req_t       axi_req_in,
   output rps_pkg::rps_axi_rsp_t            axi_rsp_out,
   input  wire logic [rps_pkg::NREF-1:0]    ref_clk_in,
   input  wire logic [1:0]                  ami_pos_in,
   input  wire logic [1:0]                  ami_neg_in,
   input  wire logic                        low_rate_align_in,
   input  wire logic                        network_select_in,
   input  wire logic                        primary_secondary_pin_in,
   input  wire logic [rps_pkg::NCH-1:0]     activity_alarm_in,
   input  wire logic [rps_pkg::NCH-1:0]     freq_oob_in,
   output logic [rps_pkg::NCH-1:0]          ref_cmp_pulse_out,
   output logic                             frame_8k_out,
   output logic                             mframe_2k_out,
   output logic                             network_type_bit_out,
   output logic [3:0]                       prio_ch11_out,
   output logic [1:0]                       lvds_sel_out,
   output logic [2*rps_pkg::NCH-1:0]        bucket_sel_out,
   output logic [rps_pkg::NCH-1:0]          freq_mon_en_out,
   output logic [rps_pkg::NCH-1:0]          ref_available_out,
   output logic [1:0]                       ami_los_out,
   output logic [1:0]                       ami_code_err_out
);
   import rps_pkg::*;

   rps_state_t st_r;
   rps_state_t st_nxt;
   logic [NSYNC-1:0] stable, rise, fall;
   logic [NCH-1:0]   ch_edge;
   logic [13:0]      n_shared;

   // Pre-divider ratio for one channel
   function automatic logic [14:0] ch_div(input logic [7:0] cfg, input logic sonet,
                                          input logic [13:0] n, input logic diff);
      logic [14:0] d;
      d = DV_ONE;
      if (cfg[MODE_PROGRAMMABLE_PREDIV]) begin
         d = 15'(n) + 15'd1;
      end else if (cfg[MODE_AUTO]) begin
         case (cfg[3:0])
            CODE_T1E1:  d = sonet ? DV_T1 : DV_E1;
            CODE_6M48:  d = DV_6M48;
            CODE_19M44: d = DV_19M44;
            CODE_25M92: d = DV_25M92;
            CODE_38M88: d = DV_38M88;
            CODE_51M84: d = DV_51M84;
            CODE_77M76: d = DV_77M76;
            CODE_155M:  d = diff ? DV_155M : DV_ONE;
            default:    d = DV_ONE;
         endcase
      end else if (diff && cfg[3:0] == CODE_155M) begin
         d = DV_HALF;
      end
      return d;
   endfunction : ch_div

   // Register index of a mapped address, valid flag in bit 8
   function automatic logic [8:0] reg_hit(input logic [11:0] addr);
      logic [7:0] idx;
      logic       ok;
      idx = addr[9:2];
      ok  = (addr[11:10] == 2'h0) && (idx == REG_TEST || (idx >= REG_FREQ0 && idx <= REG_FREQN) ||
            idx == REG_NET || idx == REG_DIFF || idx == REG_SYNC || idx == REG_STAT ||
            idx == REG_DIVLO || idx == REG_DIVHI);
      return {ok, idx};
   endfunction : reg_hit

   // Read value of a register
   function automatic logic [31:0] reg_rd(input rps_state_t s, input logic [7:0] idx);
      logic [31:0] v;
      v = 32'h0;
      if (idx >= REG_FREQ0 && idx <= REG_FREQN) begin
         v = {24'h0, s.freq_r[4'(idx - REG_FREQ0)]};
      end else begin
         case (idx)
            REG_TEST:  v = {24'h0, s.test_r};
            REG_NET:   v = {24'h0, s.net_r};
            REG_DIFF:  v = {24'h0, s.diff_r};
            REG_SYNC:  v = {24'h0, s.sync_r};
            REG_STAT:  v = {14'h0, s.err, s.los, s.avail};
            REG_DIVLO: v = {24'h0, s.divlo_r};
            REG_DIVHI: v = {24'h0, s.divhi_r};
            default:   v = 32'h0;
         endcase
      end
      return v;
   endfunction : reg_rd

   // Stable edges seen after the second and third stages agree
   assign stable = ~(st_r.s2 ^ st_r.s3);
   assign rise   = stable & st_r.s3 & ~st_r.lvl;
   assign fall   = stable & ~st_r.s3 & st_r.lvl;

   // Shared N, clamped to the legal range
   always_comb begin
      n_shared = {st_r.divhi_r[5:0], st_r.divlo_r};
      if (n_shared < DIV_N_MIN) begin
         n_shared = DIV_N_MIN;
      end else if (n_shared > DIV_N_MAX) begin
         n_shared = DIV_N_MAX;
      end
   end

   // Edge per channel; AMI channels use decoded marks
   always_comb begin
      for (int a = 0; a < 2; a++) begin
         ch_edge[a] = rise[SY_AMI + 2*a] | rise[SY_AMI + 2*a + 1];
      end
      for (int k = 2; k < NCH; k++) begin
         ch_edge[k] = st_r.test_r[EDGE_BIT] ? fall[k-2] : rise[k-2];
      end
   end

   // Next state
   always_comb begin
      logic [8:0]  hit;
      logic [14:0] dv;
      logic        mp, mn, mk, viol;
      st_nxt = st_r;
      hit    = 9'h0;
      dv     = DV_ONE;
      mp     = 1'b0;
      mn     = 1'b0;
      mk     = 1'b0;
      viol   = 1'b0;

      // Input synchronisers
      st_nxt.s1 = {primary_secondary_pin_in, network_select_in, low_rate_align_in,
                   ami_neg_in[1], ami_pos_in[1], ami_neg_in[0], ami_pos_in[0], ref_clk_in};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.lvl = (st_r.lvl & ~stable) | (st_r.s3 & stable);

      if (!st_r.strap_done) begin
         st_nxt.strap_cnt = st_r.strap_cnt + 3'd1;
         if (st_r.strap_cnt == 3'(STRAP_WAIT)) begin
            st_nxt.strap_done      = 1'b1;
            st_nxt.net_r[NET_BIT]  = st_r.lvl[SY_NET];
            st_nxt.prio11          = st_r.lvl[SY_PRIM] ? PRIO_PRIMARY : PRIO_SECONDARY;
            st_nxt.freq_r[CH11_IDX][3:0] = st_r.lvl[SY_PRIM] ? CODE_T1E1 : CODE_6M48;
         end
      end

      for (int k = 0; k < NCH; k++) begin
         dv = ch_div(st_r.freq_r[k], st_r.net_r[NET_BIT], n_shared, (k == DIFF_A) || (k == DIFF_B));
         st_nxt.cmp_pulse[k] = 1'b0;
         if (ch_edge[k]) begin
            if (st_r.cnt[k] >= dv - 15'd1) begin
               st_nxt.cmp_pulse[k] = 1'b1;
               st_nxt.cnt[k]       = 15'h0;
            end else begin
               st_nxt.cnt[k] = st_r.cnt[k] + 15'd1;
            end
         end
      end

      // AMI composite clock decoders
      for (int a = 0; a < 2; a++) begin
         mp   = rise[SY_AMI + 2*a];
         mn   = rise[SY_AMI + 2*a + 1];
         mk   = mp | mn;
         viol = st_r.seen[a] && (mn == st_r.last_pol[a]);
         st_nxt.err[a] = 1'b0;
         if (mk) begin
            st_nxt.idle[a]     = 16'h0;
            st_nxt.los[a]      = 1'b0;
            st_nxt.seen[a]     = 1'b1;
            st_nxt.last_pol[a] = mn;
            if (viol) begin
               st_nxt.err[a]    = st_r.framed[a] && (st_r.marks[a] != 3'(AMI_MARKS - 1));
               st_nxt.framed[a] = 1'b1;
               st_nxt.marks[a]  = 3'h0;
            end else if (st_r.framed[a] && st_r.marks[a] == 3'(AMI_MARKS - 1)) begin
               st_nxt.err[a]    = 1'b1;
               st_nxt.framed[a] = 1'b0;
               st_nxt.marks[a]  = 3'h0;
            end else begin
               st_nxt.marks[a] = st_r.marks[a] + 3'd1;
            end
         end else if (st_r.idle[a] == 16'(AMI_IDLE_CYC - 1)) begin
            st_nxt.los[a]    = 1'b1;
            st_nxt.framed[a] = 1'b0;
            st_nxt.seen[a]   = 1'b0;
         end else begin
            st_nxt.idle[a] = st_r.idle[a] + 16'd1;
         end
      end

      for (int k = 0; k < NCH; k++) begin
         st_nxt.mon_en[k] = ~activity_alarm_in[k] & ~((k < 2) ? st_r.los[k % 2] : 1'b0);
         st_nxt.avail[k]  = st_nxt.mon_en[k] & ~freq_oob_in[k];
      end

      // Frame and multiframe dividers
      st_nxt.f8k = (st_r.c8k == 16'(FRAME_8K_CYC - 1));
      st_nxt.f2k = (st_r.c2k == 16'(MFRAME_2K_CYC - 1));
      st_nxt.c8k = st_nxt.f8k ? 16'h0 : st_r.c8k + 16'd1;
      st_nxt.c2k = st_nxt.f2k ? 16'h0 : st_r.c2k + 16'd1;
      if (rise[SY_ALIGN]) begin
         st_nxt.c8k = 16'h0;
         if (st_r.sync_r[1:0] == SYNC_2K) begin
            st_nxt.c2k = 16'h0;
         end
      end

      // Write channel capture
      if (axi_req_in.awvalid && !st_r.aw_got && !st_r.bvalid) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.awaddr = axi_req_in.awaddr;
      end
      if (axi_req_in.wvalid && !st_r.w_got && !st_r.bvalid) begin
         st_nxt.w_got  = 1'b1;
         st_nxt.wdata  = axi_req_in.wdata[7:0];
         st_nxt.wstrb0 = axi_req_in.wstrb[0];
      end
      if (st_r.bvalid && axi_req_in.bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // Register write once both halves are held
      if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
         hit           = reg_hit(st_r.awaddr);
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp  = hit[8] ? RESP_OK : RESP_SERR;
         if (hit[8] && st_r.wstrb0) begin
            if (hit[7:0] >= REG_FREQ0 && hit[7:0] <= REG_FREQN) begin
               st_nxt.freq_r[4'(hit[7:0] - REG_FREQ0)] = st_r.wdata;
               st_nxt.cnt[4'(hit[7:0] - REG_FREQ0)] = 15'h0;
            end
            if (hit[7:0] == REG_DIVLO || hit[7:0] == REG_DIVHI) begin
               st_nxt.cnt = '0;
            end
            case (hit[7:0])
               REG_TEST:  st_nxt.test_r = st_r.wdata;
               REG_NET:   st_nxt.net_r = st_r.wdata;
               REG_DIFF:  st_nxt.diff_r = st_r.wdata;
               REG_SYNC:  st_nxt.sync_r = st_r.wdata;
               REG_DIVLO: st_nxt.divlo_r = st_r.wdata;
               REG_DIVHI: st_nxt.divhi_r = st_r.wdata;
               default:   st_nxt.test_r = st_r.test_r;
            endcase
         end
      end

      // Read channel
      if (st_r.rvalid && axi_req_in.rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (axi_req_in.arvalid && !st_r.rvalid) begin
         hit           = reg_hit(axi_req_in.araddr);
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = hit[8] ? RESP_OK : RESP_SERR;
         st_nxt.rdata  = hit[8] ? reg_rd(st_r, hit[7:0]) : 32'h0;
      end
   end

   // State register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r         <= '0;
         st_r.freq_r  <= FREQ_RST;
         st_r.diff_r  <= DIFF_RST;
         st_r.divlo_r <= DIVLO_RST;
         st_r.prio11  <= PRIO_PRIMARY;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Bus answers
   assign axi_rsp_out.awready = ~st_r.aw_got & ~st_r.bvalid;
   assign axi_rsp_out.wready  = ~st_r.w_got & ~st_r.bvalid;
   assign axi_rsp_out.bvalid  = st_r.bvalid;
   assign axi_rsp_out.bresp   = st_r.bresp;
   assign axi_rsp_out.arready = ~st_r.rvalid;
   assign axi_rsp_out.rvalid  = st_r.rvalid;
   assign axi_rsp_out.rdata   = st_r.rdata;
   assign axi_rsp_out.rresp   = st_r.rresp;

   // Block outputs
   assign ref_cmp_pulse_out    = st_r.cmp_pulse;
   assign frame_8k_out         = st_r.f8k;
   assign mframe_2k_out        = st_r.f2k;
   assign network_type_bit_out = st_r.net_r[NET_BIT];
   assign prio_ch11_out        = st_r.prio11;
   assign lvds_sel_out         = st_r.diff_r[1:0];
   assign freq_mon_en_out      = st_r.mon_en;
   assign ref_available_out    = st_r.avail;
   assign ami_los_out          = st_r.los;
   assign ami_code_err_out     = st_r.err;
   always_comb begin
      for (int k = 0; k < NCH; k++) begin
         bucket_sel_out[2*k +: 2] = st_r.freq_r[k][BUCKET_LSB +: 2];
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   a_align_frame_reset: assert property (rise[SY_ALIGN] |=> st_r.c8k == 16'h0)
      else $error("frame divider not realigned");
   a_fast_sync_free: assert property (rise[SY_ALIGN] && st_r.sync_r[1:0] != SYNC_2K && !st_nxt.f2k
      |=> st_r.c2k == $past(st_r.c2k) + 16'd1) else $error("multiframe reset by fast sync");
   a_strap_network: assert property ($rose(st_r.strap_done)
      |-> st_r.net_r[NET_BIT] == $past(st_r.lvl[SY_NET])) else $error("network strap not loaded");
   a_strap_priority: assert property ($rose(st_r.strap_done)
      |-> prio_ch11_out == ($past(st_r.lvl[SY_PRIM]) ? PRIO_PRIMARY : PRIO_SECONDARY))
      else $error("input eleven priority wrong");
   a_direct_every_edge: assert property (ch_edge[2] && st_r.freq_r[2][7:6] == 2'h0
      |=> ref_cmp_pulse_out[2]) else $error("direct mode edge lost");
   a_edge_polarity: assert property (ref_cmp_pulse_out[3]
      |-> $past(st_r.test_r[EDGE_BIT] ? fall[1] : rise[1])) else $error("wrong locking edge");
   a_programmable_prediv_ratio: assert property (ref_cmp_pulse_out[4] && $past(st_r.freq_r[4][MODE_PROGRAMMABLE_PREDIV])
      |-> $past(st_r.cnt[4]) == $past(15'(n_shared))) else $error("divide ratio not N plus one");
   a_auto_ratio: assert property (ref_cmp_pulse_out[6] && $past(st_r.freq_r[6][7:6]) == 2'h1
      && $past(st_r.freq_r[6][3:0]) == CODE_19M44 |-> $past(st_r.cnt[6]) == DV_19M44 - 15'd1)
      else $error("auto divide ratio wrong");
   a_halve_155: assert property (ref_cmp_pulse_out[5] && $past(st_r.freq_r[5]) == {4'h0, CODE_155M}
      |-> $past(st_r.cnt[5]) == 15'h1) else $error("155 input not halved");
   a_ami_idle_los: assert property (st_r.idle[0] == 16'(AMI_IDLE_CYC - 1) && !ch_edge[0]
      |=> ami_los_out[0]) else $error("loss of signal late");
   a_mon_gate: assert property (activity_alarm_in[7] |=> !freq_mon_en_out[7])
      else $error("monitor runs during alarm");
   a_unavailable: assert property (freq_oob_in[9] || activity_alarm_in[9] |=> !ref_available_out[9])
      else $error("bad reference still available");
   a_ami_spacing: assert property (ch_edge[1] && st_r.framed[1] && st_r.seen[1]
      && rise[SY_AMI + 3] == st_r.last_pol[1] && st_r.marks[1] != 3'(AMI_MARKS - 1) |=> ami_code_err_out[1])
      else $error("composite violation spacing missed");
   a_strap_code: assert property ($rose(st_r.strap_done)
      |-> st_r.freq_r[CH11_IDX][3:0] == ($past(st_r.lvl[SY_PRIM]) ? CODE_T1E1 : CODE_6M48))
      else $error("input eleven default code wrong");
   a_read_answer: assert property (axi_req_in.arvalid && axi_rsp_out.arready |=> axi_rsp_out.rvalid)
      else $error("read answer late");
   a_write_answer: assert property (st_r.aw_got && st_r.w_got && !st_r.bvalid |=> axi_rsp_out.bvalid)
      else $error("write answer late");

   c_align: cover property (rise[SY_ALIGN] ##[1:1000] frame_8k_out);
   c_halve_155: cover property (ref_cmp_pulse_out[5] && st_r.freq_r[5] == {4'h0, CODE_155M});
   c_programmable_prediv_pulse: cover property (st_r.freq_r[4][MODE_PROGRAMMABLE_PREDIV] && ref_cmp_pulse_out[4]);
   c_ami_err: cover property (ami_code_err_out[0]);
   c_ami_los: cover property ($rose(ami_los_out[1]));
endmodule : rps_top

// [hdl/rps_pkg.sv]
package rps_pkg;
   // Timing
   localparam int CLK_HZ       = 40_000_000;
   localparam int FRAME_8K_HZ  = 8000;
   localparam int MFRAME_2K_HZ = 2000;
   localparam int F8K_CYC      = CLK_HZ / FRAME_8K_HZ;
   localparam int F2K_CYC      = CLK_HZ / MFRAME_2K_HZ;
   localparam int AMI_LOS_US   = 1000;
   localparam int AMI_LOS_CYC  = (CLK_HZ / 1_000_000) * AMI_LOS_US;
   localparam int AMI_MARKS    = 8;
   localparam int STRAP_WAIT   = 5;
   // Channel and synchroniser layout
   localparam int NCH      = 14;
   localparam int NREF     = 12;
   localparam int NSYNC    = 19;
   localparam int SY_AMI   = 12;
   localparam int SY_ALIGN = 16;
   localparam int SY_NET   = 17;
   localparam int SY_PRIM  = 18;
   localparam int CH11_IDX = 10;
   localparam int DIFF_A   = 4;
   localparam int DIFF_B   = 5;
   // Register indices, byte address is four times the index
   localparam logic [7:0] REG_TEST  = 8'h03;
   localparam logic [7:0] REG_FREQ0 = 8'h20;
   localparam logic [7:0] REG_FREQN = 8'h2d;
   localparam logic [7:0] REG_NET   = 8'h34;
   localparam logic [7:0] REG_DIFF  = 8'h35;
   localparam logic [7:0] REG_SYNC  = 8'h36;
   localparam logic [7:0] REG_STAT  = 8'h37;
   localparam logic [7:0] REG_DIVLO = 8'h46;
   localparam logic [7:0] REG_DIVHI = 8'h47;
   // Field positions
   localparam int NET_BIT    = 2;
   localparam int EDGE_BIT   = 2;
   localparam int MODE_PROGRAMMABLE_PREDIV  = 7;
   localparam int MODE_AUTO  = 6;
   localparam int BUCKET_LSB = 4;
   // Shared divisor limits
   localparam logic [13:0] DIV_N_MIN = 14'h0001;
   localparam logic [13:0] DIV_N_MAX = 14'h30d3;
   // Frequency codes
   localparam logic [3:0] CODE_8K    = 4'h0;
   localparam logic [3:0] CODE_T1E1  = 4'h1;
   localparam logic [3:0] CODE_6M48  = 4'h2;
   localparam logic [3:0] CODE_19M44 = 4'h3;
   localparam logic [3:0] CODE_25M92 = 4'h4;
   localparam logic [3:0] CODE_38M88 = 4'h5;
   localparam logic [3:0] CODE_51M84 = 4'h6;
   localparam logic [3:0] CODE_77M76 = 4'h7;
   localparam logic [3:0] CODE_155M  = 4'h8;
   // Divisors down to 8 kHz, and DV_HALF for halving the 155 MHz input
   localparam logic [14:0] DV_ONE   = 15'h0001;
   localparam logic [14:0] DV_HALF  = 15'h0002;
   localparam logic [14:0] DV_T1    = 15'h00c1;
   localparam logic [14:0] DV_E1    = 15'h0100;
   localparam logic [14:0] DV_6M48  = 15'h032a;
   localparam logic [14:0] DV_19M44 = 15'h097e;
   localparam logic [14:0] DV_25M92 = 15'h0ca8;
   localparam logic [14:0] DV_38M88 = 15'h12fc;
   localparam logic [14:0] DV_51M84 = 15'h1950;
   localparam logic [14:0] DV_77M76 = 15'h25f8;
   localparam logic [14:0] DV_155M  = 15'h4bf0;
   // Reset values
   localparam logic [NCH-1:0][7:0] FREQ_RST = {8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h03,
                                               8'h03, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] DIFF_RST  = 8'h01;
   localparam logic [7:0] DIVLO_RST = 8'h01;
   localparam logic [3:0] PRIO_PRIMARY   = 4'hc;
   localparam logic [3:0] PRIO_SECONDARY = 4'h1;
   // Sync rate field and bus answers
   localparam logic [1:0] SYNC_2K   = 2'h0;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_SERR = 2'h2;

   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } rps_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } rps_axi_rsp_t;

   typedef struct packed {
      logic [NSYNC-1:0]       s1, s2, s3, lvl;
      logic [2:0]             strap_cnt;
      logic                   strap_done;
      logic [3:0]             prio11;
      logic [7:0]             test_r, net_r, diff_r, sync_r, divlo_r, divhi_r;
      logic [NCH-1:0][7:0]    freq_r;
      logic [NCH-1:0][14:0]   cnt;
      logic [NCH-1:0]         cmp_pulse, mon_en, avail;
      logic [15:0]            c8k, c2k;
      logic                   f8k, f2k;
      logic [1:0]             last_pol, seen, framed, los, err;
      logic [1:0][2:0]        marks;
      logic [1:0][15:0]       idle;
      logic                   aw_got, w_got, bvalid, rvalid;
      logic [11:0]            awaddr;
      logic [7:0]             wdata;
      logic                   wstrb0;
      logic [1:0]             bresp, rresp;
      logic [31:0]            rdata;
   } rps_state_t;
endpackage : rps_pkg

// [testbench/rps_ref_src.sv]
`timescale 1ns/1ps
module rps_ref_src (
   input  wire logic       clk_in,
   input  wire logic       ami_en_in,
   output logic            ref_clk_out,
   output logic [1:0]      ami_pos_out,
   output logic [1:0]      ami_neg_out
);
   logic [5:0] ph = 6'h00;
   logic       pol = 1'b0;
   // Free-running reference, phase unrelated to the system clock
   initial begin
      ref_clk_out = 1'b0;
      forever #97 ref_clk_out = ~ref_clk_out;
   end
   // same polarity on every eighth mark
   always @(posedge clk_in) begin
      ph <= ph + 6'h01;
      if (ph[2:0] == 3'h7 && ph[5:3] != 3'h7) pol <= ~pol;
   end
   // Marks; idle lines sit low as if tied to ground
   assign ami_pos_out = {2{ami_en_in & (ph[2:0] < 3'h4) & pol}};
   assign ami_neg_out = {2{ami_en_in & (ph[2:0] < 3'h4) & ~pol}};
endmodule : rps_ref_src

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import rps_pkg::*;
   localparam int FR = 50;
   logic                 clk_in, rst_in, rclk, ami_en, align, nsel, prim, f8, f2, nbit, cen;
   rps_axi_req_t         req;
   rps_axi_rsp_t         rsp;
   logic [NCH-1:0]       act, oob, cmp, mon, avl;
   logic [1:0]           ap, an, los, err, lv, rs;
   logic [3:0]           prio;
   logic [2*NCH-1:0]     bk;
   logic [31:0]          rd;
   logic [13:0]          n;
   logic [7:0]           d, k;
   int                   bad_count, total_checks, cyc, pc, ae, e;
   rps_top #(.FRAME_8K_CYC(FR), .MFRAME_2K_CYC(200), .AMI_IDLE_CYC(100)) u_rps_top (
      .clk_in(clk_in), .rst_in(rst_in), .axi_req_in(req), .axi_rsp_out(rsp), .ref_clk_in({12{rclk}}),
      .ami_pos_in(ap), .ami_neg_in(an), .low_rate_align_in(align), .network_select_in(nsel),
      .primary_secondary_pin_in(prim), .activity_alarm_in(act), .freq_oob_in(oob), .ref_cmp_pulse_out(cmp),
      .frame_8k_out(f8), .mframe_2k_out(f2), .network_type_bit_out(nbit), .prio_ch11_out(prio),
      .lvds_sel_out(lv), .bucket_sel_out(bk), .freq_mon_en_out(mon), .ref_available_out(avl),
      .ami_los_out(los), .ami_code_err_out(err));
   rps_ref_src u_rps_ref_src (.clk_in(clk_in), .ami_en_in(ami_en), .ref_clk_out(rclk), .ami_pos_out(ap),
      .ami_neg_out(an));
   // System clock
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   // Expected pre-divider ratio
   function automatic int expdiv(input logic [7:0] cfg, input logic [13:0] nn);
      return cfg[7] ? int'(nn) + 1 : 1;
   endfunction : expdiv
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      total_checks++;
      if (g !== ex) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, ex, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // Bus write: both channels offered, each released when taken
   task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] er);
      logic a, w, b;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.awaddr <= {2'h0, i, 2'h0};
      req.wdata <= {24'h0, v};
      req.bready <= 1'b1;
      do begin
         @(negedge clk_in);
         {a, w, b, rs} = {rsp.awready, rsp.wready, rsp.bvalid, rsp.bresp};
         @(posedge clk_in);
         if (a) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end while (!b);
      req.bready <= 1'b0;
      @(posedge clk_in);
      chk("bresp", 32'(er), 32'(rs));
   endtask : wr
   task automatic rdr(input logic [7:0] i, input logic [7:0] ev, input logic [1:0] er);
      logic a, r;
      req.arvalid <= 1'b1;
      req.araddr <= {2'h0, i, 2'h0};
      req.rready <= 1'b1;
      do begin
         @(negedge clk_in);
         {a, r, rd, rs} = {rsp.arready, rsp.rvalid, rsp.rdata, rsp.rresp};
         @(posedge clk_in);
         if (a) req.arvalid <= 1'b0;
      end while (!r);
      req.rready <= 1'b0;
      @(posedge clk_in);
      chk("rdata", {24'h0, ev}, rd);
      chk("rresp", 32'(er), 32'(rs));
   endtask : rdr
   // Hang guard and comparator pulse counter
   always @(posedge clk_in) begin
      cyc++;
      if (cen && cmp[2]) pc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      {rst_in, nsel, prim, ami_en, align, cen, act, oob} = {4'hf, 2'h0, 28'h0};
      req = '0;
      req.wstrb = 4'hf;
      void'($urandom(7981));
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      chk("net_bit", 32'h1, 32'(nbit));
      chk("prio11", 32'hc, 32'(prio));
      chk("lvds", 32'h1, 32'(lv));
      rdr(8'h34, 8'h04, RESP_OK);
      wr(8'h34, 8'h00, RESP_OK);
      wr(8'h35, 8'h02, RESP_OK);
      repeat (2) @(posedge clk_in);
      chk("net_bit", 32'h0, 32'(nbit));
      chk("lvds", 32'h2, 32'(lv));
      wr(8'h10, 8'h5a, RESP_SERR);
      rdr(8'h10, 8'h00, RESP_SERR);
      repeat (6) begin
         k = 8'($urandom_range(13));
         d = 8'($urandom);
         wr(8'h20 + k, d, RESP_OK);
         rdr(8'h20 + k, d, RESP_OK);
         chk("bucket", 32'(d[5:4]), 32'(bk[2*k+:2]));
      end
      $display("test registers done");
      wr(8'h25, {4'h0, CODE_155M}, RESP_OK);
      for (int m = 0; m < 4; m++) begin
         n = (m == 1) ? 14'h3 : (m == 3) ? 14'($urandom_range(6, 2)) : 14'h1;
         d = (m == 0) ? 8'h00 : 8'h80;
         wr(8'h46, n[7:0], RESP_OK);
         wr(8'h47, {2'h0, n[13:8]}, RESP_OK);
         wr(8'h22, d, RESP_OK);
         wr(8'h03, {5'h0, m[0], 2'h0}, RESP_OK);
         e = expdiv(d, n);
         pc = 0;
         cen <= 1'b1;
         repeat (48) @(posedge rclk);
         @(posedge clk_in);
         cen <= 1'b0;
         chk("cmp_rate", 32'h1, 32'(pc >= 48 / e - 1 && pc <= 48 / e + 1));
      end
      $display("test divider done");
      @(posedge clk_in);
      align <= 1'b1;
      // Pulses before the realignment takes hold are skipped
      repeat (5) @(negedge clk_in);
      ae = 5;
      do begin @(negedge clk_in); ae++; end while (!f8 && ae < 200);
      chk("align_delay", 32'h1, 32'(ae > FR && ae <= FR + 8));
      ae = 0;
      do begin @(negedge clk_in); ae++; end while (!f8 && ae < 200);
      chk("frame_gap", 32'(FR), 32'(ae));
      repeat (2*FR) @(negedge clk_in);
      chk("mframe", 32'h1, 32'(f2 && f8));
      @(posedge clk_in);
      align <= 1'b0;
      ami_en <= 1'b0;
      repeat (85) @(posedge clk_in);
      chk("los_early", 32'h0, 32'(los));
      repeat (30) @(posedge clk_in);
      chk("los", 32'h3, 32'(los));
      chk("avail_ami", 32'h0, 32'(avl[1:0]));
      ami_en <= 1'b1;
      wr(8'h36, 8'h02, RESP_OK);
      align <= 1'b1;
      repeat (150) @(posedge clk_in);
      chk("los_clr", 32'h0, 32'(los));
      pc = 0;
      repeat (200) begin @(negedge clk_in); if (err !== 2'b00) pc++; end
      chk("ami_err", 32'h0, 32'(pc));
      // Dropped marks must break the violation spacing
      @(posedge clk_in);
      ami_en <= 1'b0;
      repeat (16) @(posedge clk_in);
      ami_en <= 1'b1;
      pc = 0;
      repeat (100) begin @(negedge clk_in); if (err[0] === 1'b1) pc++; end
      chk("ami_gap_err", 32'h1, 32'(pc > 0));
      @(posedge clk_in);
      $display("test align and ami done");
      k = 8'($urandom_range(12, 2));
      @(posedge clk_in);
      oob <= 14'h1 << k;
      act <= 14'h1 << (k + 8'h1);
      repeat (4) @(posedge clk_in);
      chk("avail", {18'h0, ~(oob | act)}, 32'(avl));
      chk("mon_en", {18'h0, ~act}, 32'(mon));
      $display("test alarms done");
      wrap_up();
   end
endmodule : tb_top
